// ---- bench/dmp_power_ctl_bench.sv ----
// Purpose: self-checking bench for the prescaler and power control block
// Assumes: the bench acts as the system controller on the register bus
// Notes:   controller never sets rx and tx together and enables master first
`timescale 1ns/1ps
`default_nettype none
module dmp_power_ctl_bench;
  import dmp_pkg::*;
  logic        sys_clk;
  logic        resetn;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        oscillator_running;
  logic        receive_path_on;
  logic        transmit_path_on;
  logic        shutdown;
  logic        prescaler_output;
  logic [7:0]  period_len;
  logic [7:0]  high_len;
  logic [7:0]  rise_cnt;
  logic [31:0] rd;
  logic [31:0] seed;
  logic [4:0]  c;
  logic [4:0]  prev_c;
  int          num_errors;
  int          n_checks;
  int          t;

  dmp_power_ctl dmp_power_ctl_inst (.sys_clk(sys_clk), .resetn(resetn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .oscillator_running(oscillator_running), .receive_path_on(receive_path_on),
    .transmit_path_on(transmit_path_on), .shutdown(shutdown),
    .prescaler_output(prescaler_output));
  dmp_synth_model dmp_synth_model_inst (.sys_clk(sys_clk), .resetn(resetn),
    .prescaler_output(prescaler_output), .period_len(period_len),
    .high_len(high_len), .rise_cnt(rise_cnt));

  task automatic print_verdict();
    if (num_errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one bus access; request held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int i;
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_write      <= wr;
    avs_read       <= !wr;
    for (i = 0; i < 40; i++) begin
      @(posedge sys_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (i == 40) begin
      num_errors++;
      print_verdict();
    end
    repeat (3) @(posedge sys_clk);
  endtask

  // expected low six status bits; ratio bit depends on history
  function automatic logic [31:0] exp_status(input logic [4:0] k);
    return {26'h0, k == 5'h00, k[0] & k[4], k[0] & ~k[4], k[0] & k[2],
            k[0] & k[1], k[0]};
  endfunction

  task automatic wait_rises(input int n);
    logic [7:0] s;
    s = rise_cnt;
    for (t = 0; t < 300 * n && rise_cnt - s < n[7:0]; t++) @(posedge sys_clk);
    if (t >= 300 * n) begin
      num_errors++;
      print_verdict();
    end
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  initial begin
    resetn = 1'b0;
    {avs_address, avs_read, avs_write, avs_writedata, avs_byteenable} = '0;
    seed = 32'hd99f;
    num_errors = 0;
    n_checks = 0;
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    bus(1'b0, DMP_OFS_STATUS, 32'h0, 4'hf);
    chk(rd, 32'h20);
    chk({31'h0, shutdown}, 32'h1);
    bus(1'b1, DMP_OFS_CTRL, 32'h09, 4'hf);
    wait_rises(3);
    chk({24'h0, period_len}, 32'h40);
    chk({24'h0, high_len}, 32'h20);
    bus(1'b0, DMP_OFS_STATUS, 32'h0, 4'hf);
    chk(rd, 32'h49);
    bus(1'b1, DMP_OFS_CTRL, 32'h01, 4'hf);
    wait_rises(3);
    chk({24'h0, period_len}, 32'h41);
    chk({24'h0, high_len}, 32'h20);
    bus(1'b0, DMP_OFS_STATUS, 32'h0, 4'hf);
    chk(rd, 32'h09);
    bus(1'b1, DMP_OFS_CTRL, 32'h11, 4'hf);
    c = 5'h0;
    for (t = 0; t < 8; t++) begin
      rd[0] = prescaler_output;
      @(posedge sys_clk);
      c = c + {4'h0, rd[0] ^ prescaler_output};
    end
    chk({27'h0, c}, 32'h8);
    chk({31'h0, oscillator_running}, 32'h1);
    // refused writes: byte lane off, status offset, unmapped offset
    bus(1'b1, DMP_OFS_CTRL, 32'h03, 4'he);
    bus(1'b1, DMP_OFS_STATUS, 32'h7f, 4'hf);
    bus(1'b1, 4'h8, 32'h03, 4'hf);
    bus(1'b0, 4'h8, 32'h0, 4'hf);
    chk(rd, 32'h0);
    bus(1'b0, DMP_OFS_CTRL, 32'h0, 4'hf);
    chk(rd, 32'h11);
    prev_c = 5'h11;
    repeat (40) begin
      c = 5'($random(seed));
      c[0] = c[0] | c[3];
      if (c[1] && c[2]) c[2] = 1'b0;
      if (!c[0]) c = 5'h00;
      // master alone first so the oscillator settles before a path comes on
      if (c[0] && !prev_c[0]) begin
        bus(1'b1, DMP_OFS_CTRL, 32'h01, 4'hf);
      end
      bus(1'b1, DMP_OFS_CTRL, {27'h0, c}, 4'hf);
      prev_c = c;
      bus(1'b0, DMP_OFS_STATUS, 32'h0, 4'hf);
      chk(rd & 32'h3f, exp_status(c));
      chk({29'h0, transmit_path_on, receive_path_on, oscillator_running},
          exp_status(c) & 32'h7);
    end
    bus(1'b1, DMP_OFS_CTRL, 32'h0, 4'hf);
    c = 5'h0;
    for (t = 0; t < 70; t++) begin
      @(posedge sys_clk);
      c = c | {4'h0, prescaler_output};
    end
    chk({27'h0, c}, 32'h0);
    chk({31'h0, shutdown}, 32'h1);
    print_verdict();
  end
endmodule
`default_nettype wire

// ---- bench/dmp_synth_model.sv ----
// Purpose: synthesizer side model that times each prescaler output period
// Assumes: the output is sampled once per sys_clk edge
// Notes:   it only listens, so it can never disturb the divider it measures
`timescale 1ns/1ps
`default_nettype none
module dmp_synth_model (
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire logic       prescaler_output,
  output var  logic [7:0] period_len,
  output var  logic [7:0] high_len,
  output var  logic [7:0] rise_cnt
);
  logic       prev_r;
  logic [7:0] cnt_r;
  logic [7:0] hcnt_r;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      prev_r     <= 1'b0;
      cnt_r      <= 8'h00;
      hcnt_r     <= 8'h00;
      period_len <= 8'h00;
      high_len   <= 8'h00;
      rise_cnt   <= 8'h00;
    end else begin
      prev_r <= prescaler_output;
      cnt_r  <= cnt_r + 8'h01;
      if (prescaler_output) begin
        hcnt_r <= hcnt_r + 8'h01;
      end
      if (prescaler_output && !prev_r) begin
        period_len <= cnt_r;
        cnt_r      <= 8'h01;
        hcnt_r     <= 8'h01;
        rise_cnt   <= rise_cnt + 8'h01;
      end
      if (!prescaler_output && prev_r) begin
        high_len <= hcnt_r;
      end
    end
  end
endmodule
`default_nettype wire

// ---- rtl/dmp_divider.sv ----
// Purpose: dual-modulus 64/65 divider with direct buffer mode
// Assumes: every sys_clk edge is one oscillator cycle
// Notes:   ratio is taken while idle or at a period boundary; output is a flop
`timescale 1ns/1ps
`default_nettype none
module dmp_divider
  import dmp_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic resetn,
  input  wire logic div_en,
  input  wire logic buf_en,
  input  wire logic modulus_select,
  output var  logic prescaler_output,
  output var  logic ratio_is_64
);

  logic [DMP_CNT_W-1:0] cnt_r;
  logic [DMP_CNT_W-1:0] ratio_r;
  logic [DMP_CNT_W-1:0] last_cnt;
  logic [DMP_CNT_W-1:0] cnt_nxt;
  logic                 out_r;
  logic                 wrap;

  assign last_cnt = DMP_CNT_W'(ratio_r - DMP_CNT_ONE);
  assign wrap     = (cnt_r == last_cnt);
  assign cnt_nxt  = wrap ? DMP_CNT_ZERO : DMP_CNT_W'(cnt_r + DMP_CNT_ONE);

  // counter stays cleared whenever the divider is off
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= DMP_CNT_ZERO;
    end else if (!div_en) begin
      cnt_r <= DMP_CNT_ZERO;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // ratio follows the pin while idle, then only at the wrap so no cycle is cut short
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ratio_r <= DMP_RATIO_HI;
    end else if (!div_en || wrap) begin
      ratio_r <= modulus_select ? DMP_RATIO_LO : DMP_RATIO_HI;
    end
  end

  // buffer mode forwards every oscillator cycle as a toggle; divider mode drives the divided clock; otherwise static low
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      out_r <= 1'b0;
    end else if (buf_en) begin
      out_r <= ~out_r;
    end else if (div_en) begin
      out_r <= (cnt_nxt < DMP_HALF);
    end else begin
      out_r <= 1'b0;
    end
  end

  assign prescaler_output = out_r;
  assign ratio_is_64      = (ratio_r == DMP_RATIO_LO);

  AST_DIV_CLEAR: assert property (@(posedge sys_clk) disable iff (!resetn)
    (!div_en && !buf_en) |=> (cnt_r == DMP_CNT_ZERO) && !out_r)
    else $error("divider not cleared while off");

  AST_RATIO_HOLD: assert property (@(posedge sys_clk) disable iff (!resetn)
    (div_en && !wrap) |=> $stable(ratio_r))
    else $error("ratio changed inside a period");

  AST_RATIO_64: assert property (@(posedge sys_clk) disable iff (!resetn)
    (div_en && wrap && modulus_select) |=> (ratio_r == DMP_RATIO_LO))
    else $error("modulus high did not select 64");

  AST_RATIO_65: assert property (@(posedge sys_clk) disable iff (!resetn)
    (div_en && wrap && !modulus_select) |=> (ratio_r == DMP_RATIO_HI))
    else $error("modulus low did not select 65");

  AST_DIV_WRAP: assert property (@(posedge sys_clk) disable iff (!resetn)
    (div_en && cnt_r == DMP_CNT_W'(DMP_RATIO_HI - DMP_CNT_ONE) && ratio_r == DMP_RATIO_HI)
      |=> (cnt_r == DMP_CNT_ZERO))
    else $error("divide by 65 did not wrap after 65 counts");

  AST_BUF_TOGGLE: assert property (@(posedge sys_clk) disable iff (!resetn)
    (buf_en ##1 buf_en) |-> (out_r != $past(out_r)))
    else $error("buffer mode did not forward the oscillator");

endmodule
`default_nettype wire

// ---- rtl/dmp_pkg.sv ----
// Purpose: shared constants and carriers for the prescaler and power control block
// Assumes: 32-bit Avalon-MM register bus, byte addresses, one word per register
// Notes:   the oscillator is modelled by sys_clk; one clock edge is one oscillator cycle
package dmp_pkg;

  // register byte offsets
  localparam logic [3:0] DMP_OFS_CTRL   = 4'h0;
  localparam logic [3:0] DMP_OFS_STATUS = 4'h4;

  // divider ratios and counter layout
  localparam int         DMP_CNT_W      = 7;
  localparam logic [6:0] DMP_RATIO_LO   = 7'h40;  // divide by 64
  localparam logic [6:0] DMP_RATIO_HI   = 7'h41;  // divide by 65
  localparam logic [6:0] DMP_HALF       = 7'h20;  // output high for the first 32 counts
  localparam logic [6:0] DMP_CNT_ZERO   = 7'h00;
  localparam logic [6:0] DMP_CNT_ONE    = 7'h01;

  // control word, low bits of the control register
  typedef struct packed {
    logic buffer_mode_select;
    logic modulus_select;
    logic transmit_enable;
    logic receive_enable;
    logic oscillator_master_enable;
  } dmp_ctrl_s;

  localparam dmp_ctrl_s DMP_CTRL_RST = '0;

  // status word, low bits of the status register
  typedef struct packed {
    logic ratio_is_64;
    logic shutdown;
    logic buffer_active;
    logic divider_active;
    logic transmit_path_on;
    logic receive_path_on;
    logic oscillator_running;
  } dmp_status_s;

  localparam int DMP_CTRL_W   = $bits(dmp_ctrl_s);
  localparam int DMP_STATUS_W = $bits(dmp_status_s);

  // bus slave states
  typedef enum logic [1:0] {
    DMP_BUS_IDLE = 2'b01,
    DMP_BUS_ACK  = 2'b10
  } dmp_bus_e;

endpackage

// ---- rtl/dmp_power_ctl.sv ----
// Purpose: prescaler mode and power enable control behind an Avalon-MM slave
// Assumes: single clock sys_clk at 200 MHz, asynchronous active-low reset
// Notes:   control pins of the front end live in the control register
//
// The address map and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module dmp_power_ctl
  import dmp_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output var  logic [31:0] avs_readdata,
  output var  logic        avs_waitrequest,
  output var  logic        oscillator_running,
  output var  logic        receive_path_on,
  output var  logic        transmit_path_on,
  output var  logic        shutdown,
  output var  logic        prescaler_output
);

  dmp_bus_e    bus_state_r;
  logic        waitrequest_r;
  logic [31:0] readdata_r;
  dmp_ctrl_s   ctrl_r;
  dmp_ctrl_s   wdata_ctrl;
  dmp_status_s status;
  logic        osc_run_r;
  logic        rx_on_r;
  logic        tx_on_r;
  logic        shutdown_r;
  logic        div_en;
  logic        buf_en;
  logic        ratio_is_64;
  logic        req;
  logic        commit;

  assign req        = avs_read || avs_write;
  assign commit     = (bus_state_r == DMP_BUS_ACK);
  assign wdata_ctrl = dmp_ctrl_s'(avs_writedata[DMP_CTRL_W-1:0]);

  // one wait cycle per access: request seen in IDLE, answered in ACK
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bus_state_r   <= DMP_BUS_IDLE;
      waitrequest_r <= 1'b1;
    end else begin
      unique case (bus_state_r)
        DMP_BUS_IDLE: begin
          if (req) begin
            bus_state_r   <= DMP_BUS_ACK;
            waitrequest_r <= 1'b0;
          end
        end
        DMP_BUS_ACK: begin
          bus_state_r   <= DMP_BUS_IDLE;
          waitrequest_r <= 1'b1;
        end
        default: begin
          bus_state_r   <= DMP_BUS_IDLE;
          waitrequest_r <= 1'b1;
        end
      endcase
    end
  end

  // write takes effect on the edge where waitrequest is sampled low
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= DMP_CTRL_RST;
    end else if (commit && avs_write && avs_address == DMP_OFS_CTRL && avs_byteenable[0]) begin
      ctrl_r <= wdata_ctrl;
    end
  end

  always_comb begin
    status                    = '0;
    status.oscillator_running = osc_run_r;
    status.receive_path_on    = rx_on_r;
    status.transmit_path_on   = tx_on_r;
    status.divider_active     = div_en;
    status.buffer_active      = buf_en;
    status.shutdown           = shutdown_r;
    status.ratio_is_64        = ratio_is_64;
  end

  // read data is prepared while waitrequest is still high; unmapped reads give zero
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      readdata_r <= 32'h0000_0000;
    end else if (bus_state_r == DMP_BUS_IDLE && avs_read) begin
      unique case (avs_address)
        DMP_OFS_CTRL:   readdata_r <= {{(32-DMP_CTRL_W){1'b0}}, ctrl_r};
        DMP_OFS_STATUS: readdata_r <= {{(32-DMP_STATUS_W){1'b0}}, status};
        default:        readdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // oscillator depends on the master enable alone, never on the prescaler
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      osc_run_r <= 1'b0;
    end else begin
      osc_run_r <= ctrl_r.oscillator_master_enable;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rx_on_r <= 1'b0;
      tx_on_r <= 1'b0;
    end else begin
      // both paths may be on together; the controller is trusted to avoid it
      rx_on_r <= ctrl_r.oscillator_master_enable && ctrl_r.receive_enable;
      tx_on_r <= ctrl_r.oscillator_master_enable && ctrl_r.transmit_enable;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      shutdown_r <= 1'b1;
    end else begin
      shutdown_r <= (ctrl_r == DMP_CTRL_RST);
    end
  end

  // prescaler path is biased by the master enable; buffer mode picks which half runs
  assign div_en = ctrl_r.oscillator_master_enable && !ctrl_r.buffer_mode_select;
  assign buf_en = ctrl_r.oscillator_master_enable && ctrl_r.buffer_mode_select;

  dmp_divider dmp_divider_inst (
    .sys_clk          (sys_clk),
    .resetn           (resetn),
    .div_en           (div_en),
    .buf_en           (buf_en),
    .modulus_select   (ctrl_r.modulus_select),
    .prescaler_output (prescaler_output),
    .ratio_is_64      (ratio_is_64)
  );

  assign avs_readdata       = readdata_r;
  assign avs_waitrequest    = waitrequest_r;
  assign oscillator_running = osc_run_r;
  assign receive_path_on    = rx_on_r;
  assign transmit_path_on   = tx_on_r;
  assign shutdown           = shutdown_r;

  AST_OSC_RUN: assert property (@(posedge sys_clk) disable iff (!resetn)
    ctrl_r.oscillator_master_enable |=> oscillator_running)
    else $error("oscillator not running with master enable high");

  // divider off in buffer mode must leave the oscillator alone
  AST_OSC_KEEP: assert property (@(posedge sys_clk) disable iff (!resetn)
    (ctrl_r.oscillator_master_enable && !div_en) |=> oscillator_running)
    else $error("oscillator stopped with prescaler disabled");

  AST_RX_PATH: assert property (@(posedge sys_clk) disable iff (!resetn)
    (ctrl_r.oscillator_master_enable && ctrl_r.receive_enable) |=> receive_path_on)
    else $error("receive path not enabled");

  AST_RX_OFF: assert property (@(posedge sys_clk) disable iff (!resetn)
    !ctrl_r.receive_enable |=> !receive_path_on)
    else $error("receive path on with receive enable low");

  AST_TX_OFF: assert property (@(posedge sys_clk) disable iff (!resetn)
    !(ctrl_r.oscillator_master_enable && ctrl_r.transmit_enable) |=> !transmit_path_on)
    else $error("transmit path on without both enables");

  AST_SHUTDOWN: assert property (@(posedge sys_clk) disable iff (!resetn)
    (ctrl_r == DMP_CTRL_RST) [*2] |=> shutdown && !oscillator_running && !prescaler_output)
    else $error("all controls low but not in shutdown");

  AST_BUS_ACK: assert property (@(posedge sys_clk) disable iff (!resetn)
    (req && avs_waitrequest) |-> ##[1:2] !avs_waitrequest)
    else $error("bus request not answered in time");

  AST_TX_ON: assert property (@(posedge sys_clk) disable iff (!resetn)
    (ctrl_r.oscillator_master_enable && ctrl_r.transmit_enable) |=> transmit_path_on)
    else $error("transmit path not enabled");

  AST_RX_NO_MASTER: assert property (@(posedge sys_clk) disable iff (!resetn)
    !ctrl_r.oscillator_master_enable |=> !receive_path_on)
    else $error("receive path on without master enable");

  AST_SHUT_EXIT: assert property (@(posedge sys_clk) disable iff (!resetn)
    ctrl_r.oscillator_master_enable |=> !shutdown)
    else $error("shutdown shown with master enable high");

  // the answer cycle is a single cycle, so the master never sees a stale low
  AST_WAIT_ONE: assert property (@(posedge sys_clk) disable iff (!resetn)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");

  AST_WRITE_LANDS: assert property (@(posedge sys_clk) disable iff (!resetn)
    (!avs_waitrequest && avs_write && avs_address == DMP_OFS_CTRL && avs_byteenable[0])
      |=> (ctrl_r == $past(wdata_ctrl)))
    else $error("control write did not land");

  AST_WRITE_REFUSED: assert property (@(posedge sys_clk) disable iff (!resetn)
    (!avs_waitrequest && avs_write && avs_address != DMP_OFS_CTRL) |=> $stable(ctrl_r))
    else $error("write to a non-control offset changed control");

  AST_READ_UNMAPPED: assert property (@(posedge sys_clk) disable iff (!resetn)
    (!avs_waitrequest && avs_read && avs_address != DMP_OFS_CTRL
      && avs_address != DMP_OFS_STATUS) |-> (avs_readdata == 32'h0000_0000))
    else $error("unmapped read returned nonzero data");

endmodule
`default_nettype wire
